// [logic/paged_slave_serial_port.sv]
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module paged_slave_serial_port (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        serial_data_in_i,
    input  wire logic        sdio_i,
    output logic             sdio_o,
    output logic             sdio_oe_n_o,
    input  wire logic        cfg_valid_i,
    input  wire logic        cfg_i2c_mode_i,
    input  wire logic        cfg_two_byte_i,
    input  wire logic        cfg_three_wire_i,
    input  wire logic        cfg_sample_fall_i,
    input  wire logic        cfg_data_delay_i,
    input  wire logic [6:0]  cfg_i2c_base_i,
    output logic [15:0]      reg_addr_o,
    output logic [7:0]       reg_wdata_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    input  wire logic [7:0]  reg_rdata_i
);
    import serial_port_pkg::*;

    logic        cfg_done_r;
    logic        i2c_mode_r;
    logic        two_byte_r;
    logic        three_wire_r;
    logic        sample_fall_r;
    logic        data_delay_r;
    logic [6:0]  i2c_base_r;
    logic [2:0]  scl_s_r;
    logic [2:0]  sda_s_r;
    logic [1:0]  strap0_s_r;
    logic [1:0]  strap1_s_r;
    logic [2:0]  tgl_s_r;
    logic        frame_rst;
    logic        mosi;
    logic        spi_tgl;
    logic        spi_rd;
    logic [14:0] spi_off;
    logic [7:0]  spi_wd;
    logic        miso;
    logic        miso_drive;
    i2c_state_t  ist_r;
    logic [2:0]  ibit_r;
    logic        ifull_r;
    logic [7:0]  ish_r;
    logic        irw_r;
    logic [1:0]  inoff_r;
    logic [15:0] iptr_r;
    logic        pull_r;
    logic        i_req_r;
    logic        i_ev_r;
    logic        i_rd_r;
    logic [15:0] i_off_r;
    logic [7:0]  i_wd_r;
    logic [31:0] page_spi_short_r;
    logic [31:0] page_i2c_short_r;
    logic [23:0] page_spi_long_r;
    logic [4:0]  pdec_r;
    logic        rdq_r;
    logic [7:0]  wd_r;
    logic [7:0]  rd_data_r;
    logic        ev;
    logic        scl_rise;
    logic        scl_fall;
    logic        i_start;
    logic        i_stop;
    logic [6:0]  my_addr;
    logic [15:0] word_off;
    logic [31:0] pg_word;
    logic [7:0]  pg_byte;

    // full register address from offset and page
    function automatic logic [15:0] form_addr(
        input logic        i2c,
        input logic        two,
        input logic [15:0] off,
        input logic [31:0] ps,
        input logic [31:0] pi,
        input logic [23:0] pl
    );
        logic [15:0] a;
        a = off;
        if (i2c && !two) begin
            a = {pi[15:8], off[7:0]};
        end else if (!i2c && !two) begin
            a = {ps[15:7], off[6:0]};
        end else if (!i2c) begin
            a = {pl[7], off[14:0]};
        end
        return a;
    endfunction

    // page hit, target register and byte index
    function automatic logic [4:0] page_decode(
        input logic        i2c,
        input logic        two,
        input logic [15:0] off
    );
        logic [4:0] d;
        logic [1:0] li;
        d  = 5'h00;
        li = 2'(off[1:0] - 2'd1);
        if (i2c && !two && off[7:2] == `PAGE_I2C_SHORT_OFF >> 2) begin
            d = {1'b1, 2'd1, off[1:0]};
        end else if (!i2c && !two
                     && off[6:2] == `PAGE_SPI_SHORT_OFF >> 2) begin
            d = {1'b1, 2'd0, off[1:0]};
        end else if (!i2c && two && off[14:0] >= `PAGE_SPI_LONG_OFF) begin
            d = {1'b1, 2'd2, li};
        end else if (i2c && two && off >= `PAGE_I2C_LONG_OFF) begin
            d = {1'b1, 2'd2, li};
        end
        return d;
    endfunction

    // settings taken once after reset release
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_done_r    <= 1'b0;
            i2c_mode_r    <= `CFG_I2C_MODE_DEF;
            two_byte_r    <= `CFG_TWO_BYTE_DEF;
            three_wire_r  <= `CFG_THREE_WIRE_DEF;
            sample_fall_r <= `CFG_SAMPLE_FALL_DEF;
            data_delay_r  <= `CFG_DATA_DELAY_DEF;
            i2c_base_r    <= `I2C_BASE_DEF;
        end else if (!cfg_done_r) begin
            cfg_done_r <= 1'b1;
            if (cfg_valid_i) begin
                i2c_mode_r    <= cfg_i2c_mode_i;
                two_byte_r    <= cfg_two_byte_i;
                three_wire_r  <= cfg_three_wire_i;
                sample_fall_r <= cfg_sample_fall_i;
                data_delay_r  <= cfg_data_delay_i;
                i2c_base_r    <= cfg_i2c_base_i;
            end
        end
    end

    // pin and toggle synchronisers
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_s_r    <= 3'b111;
            sda_s_r    <= 3'b111;
            strap0_s_r <= 2'b00;
            strap1_s_r <= 2'b00;
            tgl_s_r    <= 3'b000;
        end else begin
            scl_s_r    <= {scl_s_r[1:0], sclk_i};
            sda_s_r    <= {sda_s_r[1:0], sdio_i};
            strap0_s_r <= {strap0_s_r[0], cs_n_i};
            strap1_s_r <= {strap1_s_r[0], serial_data_in_i};
            tgl_s_r    <= {tgl_s_r[1:0], spi_tgl};
        end
    end

    assign scl_rise = scl_s_r[1] && !scl_s_r[2];
    assign scl_fall = !scl_s_r[1] && scl_s_r[2];
    assign i_start  = scl_s_r[1] && scl_s_r[2] && !sda_s_r[1] && sda_s_r[2];
    assign i_stop   = scl_s_r[1] && scl_s_r[2] && sda_s_r[1] && !sda_s_r[2];
    assign my_addr  = {i2c_base_r[6:2], strap1_s_r[1], strap0_s_r[1]};

    // spi link side, on the serial clock
    assign frame_rst = reset_i | cs_n_i | i2c_mode_r;
    assign mosi = three_wire_r ? sdio_i : serial_data_in_i;

    spi_link_engine u_link (
        .sclk_i        (sclk_i),
        .reset_i       (reset_i),
        .frame_rst_i   (frame_rst),
        .sample_fall_i (sample_fall_r),
        .short_addr_i  (!two_byte_r),
        .data_delay_i  (data_delay_r),
        .mosi_i        (mosi),
        .rd_data_i     (rd_data_r),
        .req_tgl_o     (spi_tgl),
        .req_rd_o      (spi_rd),
        .req_off_o     (spi_off),
        .req_wdata_o   (spi_wd),
        .miso_o        (miso),
        .miso_drive_o  (miso_drive)
    );

    // i2c slave, oversampled on the core clock
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ist_r   <= I_IDLE;
            ibit_r  <= 3'd0;
            ifull_r <= 1'b0;
            ish_r   <= 8'h00;
            irw_r   <= 1'b0;
            inoff_r <= 2'd0;
            iptr_r  <= 16'h0000;
            pull_r  <= 1'b0;
            i_req_r <= 1'b0;
            i_rd_r  <= 1'b0;
            i_off_r <= 16'h0000;
            i_wd_r  <= 8'h00;
        end else begin
            i_req_r <= 1'b0;
            if (!i2c_mode_r || i_stop) begin
                ist_r  <= I_IDLE;
                pull_r <= 1'b0;
            end else if (i_start) begin
                ist_r   <= I_ADDR;
                ibit_r  <= 3'd0;
                ifull_r <= 1'b0;
                pull_r  <= 1'b0;
            end else if (scl_rise) begin
                if (ist_r == I_ADDR || ist_r == I_RX || ist_r == I_TX) begin
                    if (ist_r != I_TX) begin
                        ish_r <= {ish_r[6:0], sda_s_r[1]};
                    end
                    ibit_r <= 3'(ibit_r + 3'd1);
                    ifull_r <= ibit_r == 3'd7;
                end else if (ist_r == I_MACK) begin
                    if (sda_s_r[1]) begin
                        ist_r <= I_IDLE; // master nack ends read
                    end else begin
                        i_req_r <= 1'b1;
                        i_rd_r  <= 1'b1;
                        i_off_r <= iptr_r;
                    end
                end
            end else if (scl_fall) begin
                unique case (ist_r)
                    I_IDLE: begin
                    end
                    I_ADDR: if (ifull_r) begin
                        ifull_r <= 1'b0;
                        inoff_r <= 2'd0;
                        if (ish_r[7:1] == my_addr) begin
                            pull_r <= 1'b1;
                            ist_r  <= I_ACK;
                            irw_r  <= ish_r[0];
                            if (ish_r[0]) begin
                                i_req_r <= 1'b1;
                                i_rd_r  <= 1'b1;
                                i_off_r <= iptr_r;
                            end
                        end else begin
                            ist_r <= I_IDLE;
                        end
                    end
                    I_RX: if (ifull_r) begin
                        ifull_r <= 1'b0;
                        pull_r  <= 1'b1;
                        ist_r   <= I_ACK;
                        if (inoff_r != (two_byte_r ? 2'd2 : 2'd1)) begin
                            inoff_r <= 2'(inoff_r + 2'd1);
                            iptr_r  <= two_byte_r ? {iptr_r[7:0], ish_r}
                                                  : {8'h00, ish_r};
                        end else begin
                            i_req_r <= 1'b1;
                            i_rd_r  <= 1'b0;
                            i_off_r <= iptr_r;
                            i_wd_r  <= ish_r;
                            iptr_r  <= 16'(iptr_r + 16'd1);
                        end
                    end
                    I_ACK, I_MACK: begin
                        ibit_r <= 3'd0;
                        if (irw_r) begin
                            ish_r  <= rd_data_r;
                            pull_r <= !rd_data_r[7];
                            iptr_r <= 16'(iptr_r + 16'd1);
                            ist_r  <= I_TX;
                        end else begin
                            pull_r <= 1'b0;
                            ist_r  <= I_RX;
                        end
                    end
                    I_TX: if (ifull_r) begin
                        ifull_r <= 1'b0;
                        pull_r  <= 1'b0;
                        ist_r   <= I_MACK;
                    end else begin
                        ish_r  <= {ish_r[6:0], 1'b0};
                        pull_r <= !ish_r[6];
                    end
                endcase
            end
        end
    end

    // request source and lookup, refreshed every cycle
    assign word_off = i2c_mode_r ? i_off_r : {1'b0, spi_off};
    assign ev = i2c_mode_r ? i_ev_r : (tgl_s_r[1] ^ tgl_s_r[2]);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            i_ev_r     <= 1'b0;
            reg_addr_o <= 16'h0000;
            pdec_r     <= 5'h00;
            rdq_r      <= 1'b0;
            wd_r       <= 8'h00;
        end else begin
            i_ev_r     <= i_req_r;
            reg_addr_o <= form_addr(i2c_mode_r, two_byte_r, word_off,
                                    page_spi_short_r, page_i2c_short_r,
                                    page_spi_long_r);
            pdec_r     <= page_decode(i2c_mode_r, two_byte_r, word_off);
            rdq_r      <= i2c_mode_r ? i_rd_r : spi_rd;
            wd_r       <= i2c_mode_r ? i_wd_r : spi_wd;
        end
    end

    // page registers are served locally, the rest goes out
    assign pg_word = pdec_r[3:2] == 2'd0 ? page_spi_short_r
                   : pdec_r[3:2] == 2'd1 ? page_i2c_short_r
                   : {8'h00, page_spi_long_r};
    assign pg_byte = pg_word[pdec_r[1:0]*8 +: 8];
    assign reg_wr_o    = ev && !rdq_r && !pdec_r[4];
    assign reg_rd_o    = ev && rdq_r && !pdec_r[4];
    assign reg_wdata_o = wd_r;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            page_spi_short_r <= `PAGE_SHORT_RESET;
            page_i2c_short_r <= `PAGE_SHORT_RESET;
            page_spi_long_r  <= `PAGE_LONG_RESET;
        end else if (ev && !rdq_r && pdec_r[4]) begin
            unique case (pdec_r[3:2])
                2'd0: page_spi_short_r[pdec_r[1:0]*8 +: 8] <= wd_r;
                2'd1: page_i2c_short_r[pdec_r[1:0]*8 +: 8] <= wd_r;
                default: page_spi_long_r[pdec_r[1:0]*8 +: 8] <= wd_r;
            endcase
        end
    end

    // read data held for the link and the i2c shifter
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_r <= 8'h00;
        end else if (ev && rdq_r) begin
            rd_data_r <= pdec_r[4] ? pg_byte : reg_rdata_i;
        end
    end

    // shared data pin, enable low while driving
    assign sdio_o      = i2c_mode_r ? 1'b0 : miso;
    assign sdio_oe_n_o = i2c_mode_r ? !pull_r : !miso_drive;
endmodule

// [logic/serial_port_pkg.sv]
package serial_port_pkg;
    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_MACK
    } i2c_state_t;
endpackage

// [logic/serial_port_regs.svh]
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define PAGE_SPI_SHORT_OFF  7'h7c
`define PAGE_I2C_SHORT_OFF  8'hfc
`define PAGE_SPI_LONG_OFF   15'h7ffd
`define PAGE_I2C_LONG_OFF   16'hfffd
`define PAGE_SHORT_RESET    32'h0000_0000
`define PAGE_LONG_RESET     24'h00_0000
`define I2C_BASE_DEF        7'h58
`define CFG_I2C_MODE_DEF    1'b0
`define CFG_TWO_BYTE_DEF    1'b0
`define CFG_THREE_WIRE_DEF  1'b0
`define CFG_SAMPLE_FALL_DEF 1'b0
`define CFG_DATA_DELAY_DEF  1'b0
`define HDR_LAST_SHORT      5'd7
`define HDR_LAST_LONG       5'd15
`endif

// [logic/spi_link_engine.sv]
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module spi_link_engine (
    input  wire logic        sclk_i,
    input  wire logic        reset_i,
    input  wire logic        frame_rst_i,
    input  wire logic        sample_fall_i,
    input  wire logic        short_addr_i,
    input  wire logic        data_delay_i,
    input  wire logic        mosi_i,
    input  wire logic [7:0]  rd_data_i,
    output logic             req_tgl_o,
    output logic             req_rd_o,
    output logic [14:0]      req_off_o,
    output logic [7:0]       req_wdata_o,
    output logic             miso_o,
    output logic             miso_drive_o
);
    logic        eff_clk;
    logic [1:0]  cfg_s1_r;
    logic [1:0]  cfg_s2_r;
    logic [4:0]  hdr_cnt_r;
    logic        hdr_done_r;
    logic        rd_r;
    logic [14:0] sh_r;
    logic [14:0] off_r;
    logic [2:0]  dcnt_r;
    logic [7:0]  tx_r;
    logic        drive_r;
    logic        out_dly_r;
    logic        drv_dly_r;
    logic        hdr_last;
    logic        fire_hdr;
    logic        fire_load;
    logic        fire_wr;
    logic [14:0] addr_now;

    // sample edge chosen by clock polarity
    assign eff_clk = sclk_i ^ sample_fall_i;

    // config levels brought into the link domain
    always_ff @(posedge eff_clk or posedge reset_i) begin
        if (reset_i) begin
            cfg_s1_r <= 2'b00;
            cfg_s2_r <= 2'b00;
        end else begin
            cfg_s1_r <= {short_addr_i, data_delay_i};
            cfg_s2_r <= cfg_s1_r;
        end
    end

    // header length and the address it carries
    assign hdr_last = hdr_cnt_r == (cfg_s2_r[1] ? `HDR_LAST_SHORT
                                                : `HDR_LAST_LONG);
    assign addr_now = cfg_s2_r[1] ? {8'h00, sh_r[5:0], mosi_i}
                                  : {sh_r[13:0], mosi_i};
    assign fire_hdr  = !hdr_done_r && hdr_last && rd_r;
    assign fire_load = hdr_done_r && rd_r && dcnt_r == 3'd0;
    assign fire_wr   = hdr_done_r && !rd_r && dcnt_r == 3'd7;

    // frame state, cleared whenever chip select rises
    always_ff @(posedge eff_clk or posedge frame_rst_i) begin
        if (frame_rst_i) begin
            hdr_cnt_r  <= 5'd0;
            hdr_done_r <= 1'b0;
            rd_r       <= 1'b0;
            sh_r       <= 15'h0000;
            off_r      <= 15'h0000;
            dcnt_r     <= 3'd0;
            tx_r       <= 8'h00;
            drive_r    <= 1'b0;
        end else if (!hdr_done_r) begin
            sh_r      <= {sh_r[13:0], mosi_i};
            hdr_cnt_r <= 5'(hdr_cnt_r + 5'd1);
            if (hdr_cnt_r == 5'd0) begin
                rd_r <= mosi_i;
            end
            if (hdr_last) begin
                hdr_done_r <= 1'b1;
                off_r      <= addr_now;
            end
        end else begin
            dcnt_r <= 3'(dcnt_r + 3'd1);
            if (!rd_r) begin
                sh_r <= {sh_r[13:0], mosi_i};
                if (fire_wr) begin
                    off_r <= 15'(off_r + 15'd1);
                end
            end else if (fire_load) begin
                tx_r    <= rd_data_i;
                drive_r <= 1'b1;
                off_r   <= 15'(off_r + 15'd1);
            end else begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // request word, kept across frames so the toggle stays honest
    always_ff @(posedge eff_clk or posedge reset_i) begin
        if (reset_i) begin
            req_tgl_o   <= 1'b0;
            req_rd_o    <= 1'b0;
            req_off_o   <= 15'h0000;
            req_wdata_o <= 8'h00;
        end else if (fire_hdr) begin
            req_tgl_o <= !req_tgl_o;
            req_rd_o  <= 1'b1;
            req_off_o <= addr_now;
        end else if (fire_load) begin
            req_tgl_o <= !req_tgl_o; // prefetch next byte
            req_off_o <= 15'(off_r + 15'd1);
        end else if (fire_wr) begin
            req_tgl_o   <= !req_tgl_o;
            req_rd_o    <= 1'b0;
            req_off_o   <= off_r;
            req_wdata_o <= {sh_r[6:0], mosi_i};
        end
    end

    // half-period later copy of the output
    always_ff @(negedge eff_clk or posedge frame_rst_i) begin
        if (frame_rst_i) begin
            out_dly_r <= 1'b0;
            drv_dly_r <= 1'b0;
        end else begin
            out_dly_r <= tx_r[7];
            drv_dly_r <= drive_r;
        end
    end

    assign miso_o       = cfg_s2_r[0] ? out_dly_r : tx_r[7];
    assign miso_drive_o = cfg_s2_r[0] ? drv_dly_r : drive_r;
endmodule

// [tb/paged_slave_serial_port_tb_top.sv]
`timescale 1ns/1ps
module paged_slave_serial_port_tb_top;
    logic        core_clk_i, reset_i, cfg_valid_i, three_i;
    logic        i2c_i, scl_h, sda_h;
    logic        sclk, cs_n, serial_data_in, sdio_o, sdio_oe_n_o, reg_wr_o, reg_rd_o;
    logic [15:0] reg_addr_o;
    logic [7:0]  reg_wdata_o;
    logic [15:0] wa_q[$];
    logic [7:0]  wd_q[$];
    int          errors;
    int          samples_checked;
    wire logic   sdio_w = !sdio_oe_n_o ? sdio_o
                        : i2c_i ? sda_h : three_i ? serial_data_in : ~serial_data_in;
    paged_slave_serial_port paged_slave_serial_port_i (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .sclk_i(i2c_i ? scl_h : sclk),
        .cs_n_i(cs_n), .serial_data_in_i(i2c_i | serial_data_in), .sdio_i(sdio_w),
        .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .cfg_valid_i(cfg_valid_i),
        .cfg_i2c_mode_i(i2c_i), .cfg_two_byte_i(three_i),
        .cfg_three_wire_i(three_i), .cfg_sample_fall_i(1'b0),
        .cfg_data_delay_i(three_i), .cfg_i2c_base_i(7'h58),
        .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
        .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
        .reg_rdata_i(reg_addr_o[7:0] ^ 8'h3c));
    spi_host_model spi_host_model_i (
        .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(serial_data_in), .sdio_i(sdio_w),
        .sdio_oe_n_i(sdio_oe_n_o));
    // core clock
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    // register space write log
    always @(posedge core_clk_i) begin
        if (reg_wr_o === 1'b1) begin
            wa_q.push_back(reg_addr_o);
            wd_q.push_back(reg_wdata_o);
        end
    end
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // short page, burst of two bytes and a cut byte
    task automatic t_write();
        wa_q.delete();
        wd_q.delete();
        spi_host_model_i.frame({8'h7c, 32'h80cb_1020}, 40, 8);
        check("page wr", 16'h0, 16'(wa_q.size()));
        spi_host_model_i.frame({8'h64, 16'h5051, 16'h0}, 28, 8);
        check("wr cnt", 16'h2, 16'(wa_q.size()));
        check("wr a0", 16'hcbe4, wa_q[0]);
        check("wr d0", 16'h50, {8'h0, wd_q[0]});
        check("wr a1", 16'hcbe5, wa_q[1]);
        check("wr d1", 16'h51, {8'h0, wd_q[1]});
    endtask
    // page set then two-byte read burst of c024
    task automatic t_read(logic [39:0] pg, logic [39:0] tx, int h);
        wa_q.delete();
        spi_host_model_i.frame(pg, 40, h);
        spi_host_model_i.frame(tx, h + 17, h);
        check("hdr oe", 16'h1, {15'h0, spi_host_model_i.oe_hdr});
        check("dat oe", 16'h0, {15'h0, spi_host_model_i.oe_dat});
        check("rd", 16'h1819, spi_host_model_i.cap[15:0]);
        check("rd wr", 16'h0, 16'(wa_q.size()));
        check("end oe", 16'h1, {15'h0, sdio_oe_n_o});
    endtask
    // configured three-wire, two-byte offsets
    task automatic t_three_wire();
        @(posedge core_clk_i);
        reset_i     <= 1'b1;
        cfg_valid_i <= 1'b1;
        three_i     <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        wa_q.delete();
        wd_q.delete();
        spi_host_model_i.frame({16'h7ffd, 24'h80_1020}, 40, 16);
        spi_host_model_i.frame({16'h4be4, 8'h50, 16'h0}, 24, 16);
        check("2b a", 16'hcbe4, wa_q[0]);
        check("2b d", 16'h50, {8'h0, wd_q[0]});
        t_read({16'h7ffd, 24'h80_1020}, {16'hc024, 24'hff_ffff}, 16);
    endtask
    // i2c host levels, changed ten core cycles apart
    task automatic i2c_set(logic scl, logic sda);
        repeat (10) @(posedge core_clk_i);
        scl_h <= scl;
        sda_h <= sda;
    endtask
    task automatic i2c_start();
        i2c_set(1'b0, 1'b1);
        i2c_set(1'b1, 1'b1);
        i2c_set(1'b1, 1'b0);
    endtask
    task automatic i2c_stop();
        i2c_set(1'b0, 1'b0);
        i2c_set(1'b1, 1'b0);
        i2c_set(1'b1, 1'b1);
    endtask
    // eight bits and a released ninth, line sampled while scl is high
    task automatic i2c_byte(logic [7:0] b, output logic [8:0] got);
        logic [8:0] bits;
        bits = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            i2c_set(1'b0, bits[i]);
            i2c_set(1'b1, bits[i]);
            repeat (5) @(posedge core_clk_i);
            @(negedge core_clk_i);
            got[i] = sdio_w;
        end
    endtask
    task automatic i2c_tx(logic [7:0] b);
        logic [8:0] r;
        i2c_byte(b, r);
        check("i2c ack", 16'h0, {15'h0, r[0]});
    endtask
    // i2c one-byte offsets: page, write, read by repeated start
    task automatic t_i2c();
        logic [8:0] r;
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        i2c_i   <= 1'b1;
        three_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        wa_q.delete();
        wd_q.delete();
        i2c_start();
        i2c_tx(8'hb6);
        i2c_tx(8'hfc);
        i2c_tx(8'h00);
        i2c_tx(8'hcb);
        i2c_tx(8'h10);
        i2c_tx(8'h20);
        i2c_stop();
        i2c_start();
        i2c_tx(8'hb6);
        i2c_tx(8'he4);
        i2c_tx(8'h50);
        i2c_stop();
        check("i2c wr cnt", 16'h1, 16'(wa_q.size()));
        check("i2c wr a", 16'hcbe4, wa_q[0]);
        check("i2c wr d", 16'h50, {8'h0, wd_q[0]});
        i2c_start();
        i2c_tx(8'hb6);
        i2c_tx(8'h24);
        i2c_start();
        i2c_tx(8'hb7);
        i2c_byte(8'hff, r);
        i2c_stop();
        check("i2c rd", 16'h18, {8'h0, r[8:1]});
        check("i2c end oe", 16'h1, {15'h0, sdio_oe_n_o});
    endtask
    // main sequence
    initial begin
        reset_i         = 1'b1;
        cfg_valid_i     = 1'b0;
        three_i         = 1'b0;
        i2c_i           = 1'b0;
        scl_h           = 1'b1;
        sda_h           = 1'b1;
        errors          = 0;
        samples_checked = 0;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        check("idle oe", 16'h1, {15'h0, sdio_oe_n_o});
        t_write();
        t_read({8'h7c, 32'h00c0_1020}, {8'ha4, 32'hffff_ffff}, 8);
        t_three_wire();
        t_i2c();
        finish_test();
    end
    // hang guard
    initial begin
        #400000;
        errors++;
        finish_test();
    end
endmodule
bind paged_slave_serial_port serial_port_properties serial_port_properties_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i),
    .cfg_i2c_mode_i(cfg_i2c_mode_i), .sdio_oe_n_o(sdio_oe_n_o),
    .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o));

// [tb/serial_port_properties.sv]
`timescale 1ns/1ps
module serial_port_properties (
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic        cs_n_i,
    input wire logic        cfg_i2c_mode_i,
    input wire logic        sdio_oe_n_o,
    input wire logic [15:0] reg_addr_o,
    input wire logic        reg_wr_o,
    input wire logic        reg_rd_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    logic [15:0] last_r;
    logic        burst_r;
    logic        rd_r;
    wire         req_w = reg_wr_o | reg_rd_o;
    wire         spi_w = !cfg_i2c_mode_i;
    // previous request of the current frame
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            burst_r <= 1'b0;
            rd_r    <= 1'b0;
            last_r  <= 16'h0;
        end else if (cs_n_i) begin
            burst_r <= 1'b0;
            rd_r    <= 1'b0;
        end else if (req_w) begin
            burst_r <= 1'b1;
            rd_r    <= reg_rd_o;
            last_r  <= reg_addr_o;
        end
    end
    a_cs_release: assert property (spi_w && cs_n_i |-> sdio_oe_n_o)
        else $error("sdio driven while deselected");
    a_hdr_quiet: assert property (spi_w && $fell(cs_n_i) |-> sdio_oe_n_o [*8])
        else $error("sdio driven during header");
    a_drive_after_rd: assert property (spi_w && $fell(sdio_oe_n_o) |-> rd_r || reg_rd_o)
        else $error("sdio driven without read");
    a_burst_step: assert property (req_w && burst_r && !cs_n_i |-> reg_addr_o == last_r + 16'h1)
        else $error("burst address did not step by one");
    a_wr_spacing: assert property (reg_wr_o |=> !reg_wr_o [*3])
        else $error("write pulses too close");
    a_rd_spacing: assert property (reg_rd_o |=> !reg_rd_o [*3])
        else $error("read pulses too close");
    a_rw_excl: assert property (!(reg_wr_o && reg_rd_o))
        else $error("read and write together");
    a_idle_quiet: assert property ((spi_w && cs_n_i) [*8] |-> !req_w)
        else $error("request while deselected");
    c_write: cover property (reg_wr_o);
    c_read: cover property (reg_rd_o && burst_r);
    c_drive: cover property ($fell(sdio_oe_n_o));
endmodule

// [tb/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    input  wire logic sdio_i,
    input  wire logic sdio_oe_n_i
);
    logic [39:0] cap;
    logic        oe_hdr;
    logic        oe_dat;
    // clock idles low outside frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end
    // one frame, msb of tx first; h header bits
    task automatic frame(input logic [39:0] tx, input int n, input int h);
        cap = '0;
        #7 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi_o = tx[39-i];
            #40;
            cap = {cap[38:0], sdio_i};
            if (i == h) oe_hdr = sdio_oe_n_i;
            if (i == h + 1) oe_dat = sdio_oe_n_i;
            sclk_o = 1'b1;
            #40 sclk_o = 1'b0;
        end
        sdi_o = ~sdi_o; // no stale level after release
        #200 cs_n_o = 1'b1;
        #400;
    endtask
endmodule
